/* logic/bsom_monitor.sv */
// Purpose: short and open-load supervision for bridges A and B
// Assumes: comparators are asynchronous pins, synchronised here
// Notes: level codes are passed to the analog comparators
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/10ps
`include "bsom_cfg.svh"
module bsom_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // configuration
  input wire logic drv_enable,
  input wire logic [1:0] short_filter,
  input wire logic short_delay_high,
  input wire logic [3:0] lowside_overcurrent_level,
  input wire logic [3:0] highside_ground_short_level,
  input wire logic level_write,
  input wire logic otp_ls_high,
  input wire logic [3:0] otp_hs_level,
  input wire logic disable_supply_short_check,
  input wire logic disable_ground_short_check,
  // analog side
  input wire logic cmp_gnd_a,
  input wire logic cmp_sup_a,
  input wire logic cmp_gnd_b,
  input wire logic cmp_sup_b,
  input wire logic switch_a,
  input wire logic switch_b,
  input wire logic reg_miss_a,
  input wire logic reg_miss_b,
  input wire logic standstill,
  // outputs
  output logic bridge_a_on,
  output logic bridge_b_on,
  output logic [3:0] ls_level_out,
  output logic [3:0] hs_level_out,
  output logic bridge_a_ground_fault,
  output logic bridge_b_ground_fault,
  output logic bridge_a_supply_fault,
  output logic bridge_b_supply_fault,
  output logic open_load_a,
  output logic open_load_b
);
  import bsom_pkg::*;
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] ls;
    logic [3:0] hs;
    logic otp_done;
    logic ola;
    logic olb;
  } bsom_top_t;
  bsom_top_t t_q, t_d;
  logic [7:0] filt_cycles, blank_cycles;
  logic gnd_a, sup_a, gnd_b, sup_b;
  //------------------------------------------------------------
  // timing selection
  //------------------------------------------------------------
  // rounded-up counts
  always_comb begin
    case (short_filter)
      2'h0: filt_cycles = 8'(`BSOM_CYC(`BSOM_FILT0_NS));
      2'h1: filt_cycles = 8'(`BSOM_CYC(`BSOM_FILT1_NS));
      2'h2: filt_cycles = 8'(`BSOM_CYC(`BSOM_FILT2_NS));
      default: filt_cycles = 8'(`BSOM_CYC(`BSOM_FILT3_NS));
    endcase
    blank_cycles = short_delay_high ? 8'(`BSOM_CYC(`BSOM_BLANK_HIGH_NS)) : 8'(`BSOM_CYC(`BSOM_BLANK_NORM_NS));
  end
  //------------------------------------------------------------
  // state update
  //------------------------------------------------------------
  always_comb begin
    t_d = t_q;
    // two-stage synchronisers, second stage only read
    t_d.s1 = {cmp_gnd_a, cmp_sup_a, cmp_gnd_b, cmp_sup_b};
    t_d.s2 = t_q.s1;
    // OTP reset value caught after release
    if (!t_q.otp_done) begin
      t_d.otp_done = 1'b1;
      t_d.ls = otp_ls_high ? `BSOM_OTP_LS_HIGH : `BSOM_OTP_LS_LOW;
      t_d.hs = (otp_hs_level < `BSOM_HS_LEVEL_MIN) ? `BSOM_HS_LEVEL_MIN : otp_hs_level;
    end else if (level_write) begin
      t_d.ls = (lowside_overcurrent_level < `BSOM_LS_LEVEL_MIN) ? `BSOM_LS_LEVEL_MIN : lowside_overcurrent_level;
      t_d.hs = (highside_ground_short_level < `BSOM_HS_LEVEL_MIN) ? `BSOM_HS_LEVEL_MIN
               : highside_ground_short_level;
    end
    if (!standstill) begin
      t_d.ola = reg_miss_a;
      t_d.olb = reg_miss_b;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) t_q <= '0;
    else t_q <= t_d;
  end
  assign gnd_a = t_q.s2[3] & ~disable_ground_short_check;
  assign gnd_b = t_q.s2[1] & ~disable_ground_short_check;
  assign sup_a = t_q.s2[2] & ~disable_supply_short_check;
  assign sup_b = t_q.s2[0] & ~disable_supply_short_check;
  //------------------------------------------------------------
  // bridges
  //------------------------------------------------------------
  // independent bridges
  bsom_bridge u_br_a (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .drv_enable(drv_enable),
    .switch_event(switch_a),
    .filt_cycles(filt_cycles),
    .blank_cycles(blank_cycles),
    .gnd_short_in(gnd_a),
    .sup_short_in(sup_a),
    .bridge_on(bridge_a_on),
    .ground_fault(bridge_a_ground_fault),
    .supply_fault(bridge_a_supply_fault)
  );
  bsom_bridge u_br_b (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .drv_enable(drv_enable),
    .switch_event(switch_b),
    .filt_cycles(filt_cycles),
    .blank_cycles(blank_cycles),
    .gnd_short_in(gnd_b),
    .sup_short_in(sup_b),
    .bridge_on(bridge_b_on),
    .ground_fault(bridge_b_ground_fault),
    .supply_fault(bridge_b_supply_fault)
  );
  assign open_load_a = t_q.ola;
  assign open_load_b = t_q.olb;
  assign ls_level_out = t_q.ls;
  assign hs_level_out = t_q.hs;
  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  property p_ls_range;
    @(posedge clk_sys) disable iff (!nrst) t_q.otp_done |-> ls_level_out >= `BSOM_LS_LEVEL_MIN;
  endproperty
  a_ls_range: assert property (p_ls_range) else $error("low-side level below 4");
  property p_hs_range;
    @(posedge clk_sys) disable iff (!nrst) t_q.otp_done |-> hs_level_out >= `BSOM_HS_LEVEL_MIN;
  endproperty
  a_hs_range: assert property (p_hs_range) else $error("high-side level below 2");
  property p_sup_off;
    @(posedge clk_sys) disable iff (!nrst)
      disable_supply_short_check |=> !$rose(bridge_a_supply_fault) && !$rose(bridge_b_supply_fault);
  endproperty
  a_sup_off: assert property (p_sup_off) else $error("supply check not disabled");
  property p_gnd_off;
    @(posedge clk_sys) disable iff (!nrst)
      disable_ground_short_check |=> !$rose(bridge_a_ground_fault) && !$rose(bridge_b_ground_fault);
  endproperty
  a_gnd_off: assert property (p_gnd_off) else $error("ground check not disabled");
  property p_stst_hold;
    @(posedge clk_sys) disable iff (!nrst) standstill |=> $stable(open_load_a) && $stable(open_load_b);
  endproperty
  a_stst_hold: assert property (p_stst_hold) else $error("open load changed at standstill");
  property p_ol_follow;
    @(posedge clk_sys) disable iff (!nrst) !standstill && reg_miss_a |=> open_load_a;
  endproperty
  a_ol_follow: assert property (p_ol_follow) else $error("open load a missed");
  property p_a_only;
    @(posedge clk_sys) disable iff (!nrst) $rose(bridge_a_ground_fault) && !gnd_b |-> !$rose(bridge_b_ground_fault);
  endproperty
  a_a_only: assert property (p_a_only) else $error("bridge b flagged by a");
  property p_b_only;
    @(posedge clk_sys) disable iff (!nrst) $rose(bridge_b_supply_fault) && !sup_a |-> !$rose(bridge_a_supply_fault);
  endproperty
  a_b_only: assert property (p_b_only) else $error("bridge a flagged by b");
  //------------------------------------------------------------
  // level and status checks
  //------------------------------------------------------------
  property p_otp_ls;
    @(posedge clk_sys) disable iff (!nrst)
      !t_q.otp_done |=> ls_level_out == ($past(otp_ls_high) ? `BSOM_OTP_LS_HIGH : `BSOM_OTP_LS_LOW);
  endproperty
  a_otp_ls: assert property (p_otp_ls) else $error("low-side level missed its OTP value");
  property p_ls_take;
    @(posedge clk_sys) disable iff (!nrst)
      t_q.otp_done && level_write && lowside_overcurrent_level >= `BSOM_LS_LEVEL_MIN
        |=> ls_level_out == $past(lowside_overcurrent_level);
  endproperty
  a_ls_take: assert property (p_ls_take) else $error("low-side level write lost");
  property p_ls_clamp;
    @(posedge clk_sys) disable iff (!nrst)
      t_q.otp_done && level_write && lowside_overcurrent_level < `BSOM_LS_LEVEL_MIN
        |=> ls_level_out == `BSOM_LS_LEVEL_MIN;
  endproperty
  a_ls_clamp: assert property (p_ls_clamp) else $error("low-side level not clamped");
  property p_hs_take;
    @(posedge clk_sys) disable iff (!nrst)
      t_q.otp_done && level_write && highside_ground_short_level >= `BSOM_HS_LEVEL_MIN
        |=> hs_level_out == $past(highside_ground_short_level);
  endproperty
  a_hs_take: assert property (p_hs_take) else $error("high-side level write lost");
  property p_hs_clamp;
    @(posedge clk_sys) disable iff (!nrst)
      t_q.otp_done && level_write && highside_ground_short_level < `BSOM_HS_LEVEL_MIN
        |=> hs_level_out == `BSOM_HS_LEVEL_MIN;
  endproperty
  a_hs_clamp: assert property (p_hs_clamp) else $error("high-side level not clamped");
  property p_ol_drop;
    @(posedge clk_sys) disable iff (!nrst) !standstill && !reg_miss_b |=> !open_load_b;
  endproperty
  a_ol_drop: assert property (p_ol_drop) else $error("open load b stuck");
  c_fault_a: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(bridge_a_supply_fault));
  c_open_b: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(open_load_b));
  c_reenable: cover property (@(posedge clk_sys) disable iff (!nrst) bridge_a_ground_fault ##1 !drv_enable);
endmodule : bsom_monitor

/* logic/bsom_cfg.svh */
// Purpose: constants for the bridge short and open-load monitor
// Assumes: clk_sys at 25 MHz
// Notes: times in ns, cycle counts derived and rounded up
`ifndef BSOM_CFG_SVH
`define BSOM_CFG_SVH
`define BSOM_CLK_NS 40
`define BSOM_FILT0_NS 100
`define BSOM_FILT1_NS 1000
`define BSOM_FILT2_NS 2000
`define BSOM_FILT3_NS 3000
`define BSOM_BLANK_NORM_NS 750
`define BSOM_BLANK_HIGH_NS 1500
`define BSOM_CYC(ns) (((ns) + `BSOM_CLK_NS - 1) / `BSOM_CLK_NS)
`define BSOM_RETRIES 3
`define BSOM_FILTER_RESET 2'h1
`define BSOM_LS_LEVEL_MIN 4'h4
`define BSOM_HS_LEVEL_MIN 4'h2
`define BSOM_OTP_LS_LOW 4'h6
`define BSOM_OTP_LS_HIGH 4'hC
`define BSOM_CNT_W 8
`endif

/* logic/bsom_pkg.sv */
// Purpose: types for the bridge short and open-load monitor
// Assumes: nothing
// Notes: shared by both design files
package bsom_pkg;
  typedef enum logic [1:0] {
    BSOM_RUN = 2'b00,
    BSOM_BLANK = 2'b01,
    BSOM_RETRY = 2'b10,
    BSOM_LATCHED = 2'b11
  } bsom_state_t;
endpackage : bsom_pkg

/* logic/bsom_bridge.sv */
// Purpose: short qualification, retry and latch for one bridge
// Assumes: comparator inputs already synchronised
// Notes: one instance per bridge
`timescale 1ns/10ps
`include "bsom_cfg.svh"
module bsom_bridge (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic drv_enable,
  input wire logic switch_event,
  input wire logic [7:0] filt_cycles,
  input wire logic [7:0] blank_cycles,
  // qualified comparator levels
  input wire logic gnd_short_in,
  input wire logic sup_short_in,
  // results
  output logic bridge_on,
  output logic ground_fault,
  output logic supply_fault
);
  import bsom_pkg::*;
  typedef struct packed {
    bsom_state_t st;
    logic [7:0] blank;
    logic [7:0] filt;
    logic [1:0] retries;
    logic on;
    logic gf;
    logic sf;
  } bsom_br_t;
  bsom_br_t r_q, r_d;
  logic shorted;
  logic latch_now;
  assign shorted = gnd_short_in | sup_short_in;
  always_comb begin
    r_d = r_q;
    latch_now = 1'b0;
    // spike filter: count persisting indication
    if (shorted && r_q.st == BSOM_RUN) begin
      if (r_q.filt != 8'hFF) r_d.filt = r_q.filt + 8'h01;
    end else begin
      r_d.filt = 8'h00;
    end
    case (r_q.st)
      BSOM_RUN: begin
        r_d.on = 1'b1;
        if (switch_event) begin
          r_d.st = BSOM_BLANK;
          r_d.blank = blank_cycles;
          r_d.filt = 8'h00;
        end else if (shorted && r_q.filt + 8'h01 >= filt_cycles) begin
          if (r_q.retries == 2'(`BSOM_RETRIES)) begin
            latch_now = 1'b1;
            r_d.st = BSOM_LATCHED;
            r_d.on = 1'b0;
            r_d.gf = gnd_short_in;
            r_d.sf = sup_short_in;
          end else begin
            r_d.retries = r_q.retries + 2'h1;
            r_d.st = BSOM_RETRY;
            r_d.on = 1'b0;
            r_d.blank = blank_cycles;
          end
          r_d.filt = 8'h00;
        end
      end
      BSOM_BLANK, BSOM_RETRY: begin
        r_d.on = 1'b1;
        if (r_q.blank <= 8'h01) r_d.st = BSOM_RUN;
        else r_d.blank = r_q.blank - 8'h01;
      end
      BSOM_LATCHED: begin
        r_d.on = 1'b0;
      end
      default: r_d.st = BSOM_RUN;
    endcase
    // disable clears budget and flags
    // a latch confirmed in the clearing cycle wins over the clear
    if (!drv_enable && !latch_now) begin
      r_d = '0;
      r_d.st = BSOM_RUN;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) r_q <= '0;
    else r_q <= r_d;
  end
  assign bridge_on = r_q.on;
  assign ground_fault = r_q.gf;
  assign supply_fault = r_q.sf;
  property p_latch_hold;
    @(posedge clk_sys) disable iff (!nrst)
      (r_q.st == BSOM_LATCHED && drv_enable) |=> !bridge_on;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched bridge turned on");
  property p_flag_needs_latch;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(ground_fault) || $rose(supply_fault) |-> r_q.retries == 2'(`BSOM_RETRIES);
  endproperty
  a_flag_needs_latch: assert property (p_flag_needs_latch) else $error("fault flag before retries");
  property p_disable_clears;
    @(posedge clk_sys) disable iff (!nrst)
      !drv_enable && !latch_now |=> (r_q.retries == 2'h0 && !ground_fault && !supply_fault);
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("disable did not clear");
  property p_set_wins;
    @(posedge clk_sys) disable iff (!nrst)
      !drv_enable && latch_now |=> ground_fault || supply_fault;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a confirmed short");
  c_latch: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(r_q.st == BSOM_LATCHED));
endmodule : bsom_bridge

/* sim/bsom_partner.sv */
// Purpose: far-side model of the bridge short comparators
// Assumes: a short only shows while its bridge conducts
// Notes: switching pulses are requested by the bench
`timescale 1ns/10ps
module bsom_partner (
  // bridge state
  input wire logic bridge_a_on,
  input wire logic bridge_b_on,
  // injected faults: gnd a, sup a, gnd b, sup b
  input wire logic [3:0] short_set,
  input wire logic [1:0] sw_req,
  // comparators and switching
  output logic cmp_gnd_a,
  output logic cmp_sup_a,
  output logic cmp_gnd_b,
  output logic cmp_sup_b,
  output logic switch_a,
  output logic switch_b
);
  // a switched-off bridge carries no current, so its comparators fall
  assign cmp_gnd_a = short_set[0] & bridge_a_on;
  assign cmp_sup_a = short_set[1] & bridge_a_on;
  assign cmp_gnd_b = short_set[2] & bridge_b_on;
  assign cmp_sup_b = short_set[3] & bridge_b_on;
  assign switch_a = sw_req[0];
  assign switch_b = sw_req[1];
endmodule : bsom_partner

/* sim/bsom_monitor_test.sv */
// Purpose: self-checking bench for the bridge short and open-load monitor
// Assumes: filter codes give 3, 25, 50 and 75 cycles; blanking 19 or 38
// Notes: falls of bridge_x_on are counted on the falling clock edge
`timescale 1ns/10ps
module bsom_monitor_test;
  import bsom_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic drv_enable = 1'b1;
  logic [1:0] short_filter = 2'h0;
  logic short_delay_high = 1'b0;
  logic [3:0] ls_lvl = 4'h0, hs_lvl = 4'h0, short_set = 4'h0;
  logic level_write = 1'b0, otp_ls_high = 1'b1, dis_sup = 1'b0, dis_gnd = 1'b0;
  logic reg_miss_a = 1'b0, reg_miss_b = 1'b0, standstill = 1'b0;
  logic [1:0] sw_req = 2'h0;
  logic [3:0] otp_hs_level = 4'h9;
  logic cga, csa, cgb, csb, swa, swb, on_a, on_b, fga, fgb, fsa, fsb, ola, olb;
  logic [3:0] ls_out, hs_out;
  logic on_a_q = 1'b0, on_b_q = 1'b0;
  int miscompares = 0, n_compared = 0, falls = 0, f0;
  logic [3:0] flags;
  logic [7:0] thr [4] = '{8'h03, 8'h19, 8'h32, 8'h4B};
  assign flags = {fsb, fgb, fsa, fga};
  always #20 clk_sys = ~clk_sys;
  bsom_monitor dut_u (.clk_sys(clk_sys), .nrst(nrst), .drv_enable(drv_enable), .short_filter(short_filter),
    .short_delay_high(short_delay_high), .lowside_overcurrent_level(ls_lvl), .highside_ground_short_level(hs_lvl),
    .level_write(level_write), .otp_ls_high(otp_ls_high), .otp_hs_level(otp_hs_level),
    .disable_supply_short_check(dis_sup), .disable_ground_short_check(dis_gnd), .cmp_gnd_a(cga), .cmp_sup_a(csa),
    .cmp_gnd_b(cgb), .cmp_sup_b(csb), .switch_a(swa), .switch_b(swb), .reg_miss_a(reg_miss_a),
    .reg_miss_b(reg_miss_b), .standstill(standstill), .bridge_a_on(on_a), .bridge_b_on(on_b),
    .ls_level_out(ls_out), .hs_level_out(hs_out), .bridge_a_ground_fault(fga), .bridge_b_ground_fault(fgb),
    .bridge_a_supply_fault(fsa), .bridge_b_supply_fault(fsb), .open_load_a(ola), .open_load_b(olb));
  bsom_partner partner_u (.bridge_a_on(on_a), .bridge_b_on(on_b), .short_set(short_set), .sw_req(sw_req),
    .cmp_gnd_a(cga), .cmp_sup_a(csa), .cmp_gnd_b(cgb), .cmp_sup_b(csb), .switch_a(swa), .switch_b(swb));
  always @(negedge clk_sys) begin
    on_a_q <= on_a;
    on_b_q <= on_b;
    if ((on_a_q && !on_a) || (on_b_q && !on_b)) falls++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // disable then enable the driver, restoring the retry budget
  task automatic rearm;
    @(posedge clk_sys) drv_enable <= 1'b0;
    @(posedge clk_sys) drv_enable <= 1'b1;
    tick(50);
  endtask : rearm
  task automatic wr_lvl(input logic [3:0] ls, input logic [3:0] hs);
    @(posedge clk_sys) begin
      ls_lvl <= ls;
      hs_lvl <= hs;
      level_write <= 1'b1;
    end
    @(posedge clk_sys) level_write <= 1'b0;
    tick(3);
  endtask : wr_lvl
  // hold one short for a long span, then compare falls, flags and bridges
  task automatic fault(input int i, input logic [3:0] exp, input logic [7:0] nf);
    f0 = falls;
    @(posedge clk_sys) short_set <= 4'h1 << i;
    tick(300);
    check(8'(falls - f0), nf);
    check({4'h0, flags}, {4'h0, exp});
    check({6'h0, on_b, on_a}, {6'h0, 2'h3 & ~{|exp[3:2], |exp[1:0]}});
    @(posedge clk_sys) short_set <= 4'h0;
    tick(20);
    check({6'h0, on_b, on_a}, {6'h0, 2'h3 & ~{|exp[3:2], |exp[1:0]}});
    rearm();
    check({2'h0, on_b, on_a, flags}, 8'h30);
  endtask : fault
  // short on bridge a for len + 1 cycles, optionally with a switching pulse
  task automatic pulse(input int len, input logic sw, input logic [7:0] nf);
    f0 = falls;
    @(posedge clk_sys) begin
      short_set <= 4'h1;
      sw_req <= {1'b0, sw};
    end
    @(posedge clk_sys) sw_req <= 2'h0;
    tick(len - 1);
    @(posedge clk_sys) short_set <= 4'h0;
    tick(40);
    check(8'(falls - f0), nf);
    rearm();
  endtask : pulse
  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    tick(8);
    check({2'h0, on_b, on_a, flags}, 8'h00);
    @(posedge clk_sys) nrst <= 1'b1;
    tick(3);
    check({ls_out, hs_out}, 8'hC9);
    // level codes clamp to their minimum
    wr_lvl(4'h2, 4'h1);
    check({ls_out, hs_out}, 8'h42);
    wr_lvl(4'hF, 4'hF);
    check({ls_out, hs_out}, 8'hFF);
    tick(50);
    for (int i = 0; i < 4; i++) fault(i, 4'h1 << i, 8'h04);
    @(posedge clk_sys) dis_gnd <= 1'b1;
    fault(0, 4'h0, 8'h00);
    fault(3, 4'h8, 8'h04);
    @(posedge clk_sys) dis_sup <= 1'b1;
    fault(1, 4'h0, 8'h00);
    fault(3, 4'h0, 8'h00);
    @(posedge clk_sys) {dis_gnd, dis_sup} <= 2'h0;
    // each filter code just below and above its length
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys) short_filter <= 2'(c);
      pulse(int'(thr[c]) - 2, 1'b0, 8'h00);
      pulse(int'(thr[c]) + 6, 1'b0, 8'h01);
    end
    @(posedge clk_sys) short_filter <= 2'h0;
    // a short inside the blanking span is ignored
    pulse(12, 1'b1, 8'h00);
    @(posedge clk_sys) short_delay_high <= 1'b1;
    pulse(31, 1'b1, 8'h00);
    pulse(31, 1'b0, 8'h01);
    pulse(45, 1'b1, 8'h01);
    // open load is status only and frozen at standstill
    @(posedge clk_sys) reg_miss_a <= 1'b1;
    tick(3);
    check({6'h0, ola, olb}, 8'h02);
    check({6'h0, on_b, on_a}, 8'h03);
    @(posedge clk_sys) begin
      standstill <= 1'b1;
      reg_miss_b <= 1'b1;
    end
    tick(3);
    check({7'h0, olb}, 8'h00);
    @(posedge clk_sys) standstill <= 1'b0;
    tick(3);
    check({6'h0, ola, olb}, 8'h03);
    // second reset picks up the other OTP levels
    @(posedge clk_sys) begin
      nrst <= 1'b0;
      otp_ls_high <= 1'b0;
      otp_hs_level <= 4'h6;
    end
    tick(2);
    check({ola, olb, on_b, on_a, flags}, 8'h00);
    @(posedge clk_sys) nrst <= 1'b1;
    tick(3);
    check({ls_out, hs_out}, 8'h66);
    complete_run();
  end
  initial begin
    #1000000;
    miscompares++;
    complete_run();
  end
endmodule : bsom_monitor_test
